// File: adad_chan.sv
// Shared constants and one acquisition channel: source select, gate
// synchroniser, descriptor chain walk and sample counting.
// Assumes converter and playback streams are synchronous to clk; the
// gate arrives from a pin and is synchronised here.
package adad_pkg;
  localparam int N_CHAN = 4;
  localparam int N_BANK = 2;
  localparam int CHAN_IW = 2;
  localparam int SAMPLE_W = 16;
  localparam int WORD_W = 32;
  localparam int TS_W = 32;
  localparam int LEN_W = 16;
  localparam int DESC_N = 8;
  localparam int DESC_IW = 3;
  localparam int REGION_AW = 10;
  localparam int BANK_AW = REGION_AW + 1;
  localparam int SRC_W = 3;
  localparam logic [SRC_W-1:0] SRC_TEST = 3'h4;
  localparam logic [SRC_W-1:0] SRC_LOOP = 3'h5;
  localparam logic [REGION_AW:0] REGION_DEPTH = 11'h400;
  localparam logic [REGION_AW:0] META_WORDS = 11'h002;
  localparam logic [1:0] HDR_WORDS = 2'h2;
  localparam logic [7:0] HDR_PAD = 8'h00;
endpackage : adad_pkg

module adad_chan #(
  parameter int CHAN_ID = 0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic gate_pin,
  input wire logic [adad_pkg::SRC_W-1:0] src_sel,
  input wire logic [adad_pkg::N_CHAN-1:0][adad_pkg::SAMPLE_W-1:0] adc_data,
  input wire logic [adad_pkg::N_CHAN-1:0] adc_valid,
  input wire logic [adad_pkg::N_CHAN-1:0][adad_pkg::SAMPLE_W-1:0] pb_data,
  input wire logic [adad_pkg::N_CHAN-1:0] pb_valid,
  input wire logic run,
  input wire logic hold_off,
  input wire logic desc_wr,
  input wire logic [adad_pkg::DESC_IW-1:0] desc_idx,
  input wire logic [adad_pkg::LEN_W-1:0] desc_len,
  input wire logic desc_gated,
  input wire logic [adad_pkg::DESC_IW-1:0] desc_next,
  input wire logic desc_stop,
  input wire logic [adad_pkg::DESC_IW-1:0] first_idx,
  input wire logic [adad_pkg::TS_W-1:0] ts,
  input wire logic s_ready,
  output logic s_valid,
  output logic [adad_pkg::SAMPLE_W-1:0] s_data,
  output logic x_start,
  output logic x_done,
  output logic [adad_pkg::LEN_W-1:0] x_len,
  output logic [adad_pkg::TS_W-1:0] x_ts,
  output logic busy,
  output logic dropped
);
  import adad_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_XFER, ST_END} adad_st_t;

  adad_st_t state;
  logic gate_m, gate_s, gate_q;
  logic [SAMPLE_W-1:0] ramp;
  logic [LEN_W-1:0] len_tab [DESC_N];
  logic gated_tab [DESC_N];
  logic [DESC_IW-1:0] next_tab [DESC_N];
  logic stop_tab [DESC_N];
  logic [DESC_IW-1:0] cur;
  logic [LEN_W-1:0] count;
  logic src_valid;
  logic [SAMPLE_W-1:0] src_data;
  logic gate_rise, room_ok, end_now, want;

  // ---------------------------------------------------------------
  // Gate synchroniser and test ramp
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_m <= 1'b0;
      gate_s <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      gate_m <= gate_pin;
      gate_s <= gate_m;
      gate_q <= gate_s;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ramp <= '0;
    end else begin
      ramp <= ramp + 1'b1;
    end
  end

  assign gate_rise = gate_s & ~gate_q;

  // ---------------------------------------------------------------
  // Source select
  // ---------------------------------------------------------------
  always_comb begin
    src_valid = 1'b0;
    src_data = '0;
    if (!src_sel[2]) begin
      src_valid = adc_valid[src_sel[1:0]];
      src_data = adc_data[src_sel[1:0]];
    end else if (src_sel == SRC_TEST) begin
      src_valid = 1'b1;
      src_data = ramp;
    end else if (src_sel == SRC_LOOP) begin
      src_valid = pb_valid[CHAN_ID];
      src_data = pb_data[CHAN_ID];
    end
  end

  // ---------------------------------------------------------------
  // Descriptor table
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DESC_N; i++) begin
        len_tab[i] <= '0;
        gated_tab[i] <= 1'b0;
        next_tab[i] <= '0;
        stop_tab[i] <= 1'b1;
      end
    end else if (desc_wr) begin
      len_tab[desc_idx] <= desc_len;
      gated_tab[desc_idx] <= desc_gated;
      next_tab[desc_idx] <= desc_next;
      stop_tab[desc_idx] <= desc_stop;
    end
  end

  // ---------------------------------------------------------------
  // Transfer control
  // ---------------------------------------------------------------
  assign room_ok = gated_tab[cur] ? gate_s : (count != len_tab[cur]);
  assign end_now = gated_tab[cur] ? (~gate_s | (&count))
                                  : (count == len_tab[cur]);
  assign want = src_valid & ((state == ST_XFER) ? (room_ok & ~(&count))
                : (x_start & (gated_tab[cur] | (len_tab[cur] != '0))));
  assign s_valid = want;
  assign s_data = src_data;
  assign dropped = want & ~s_ready;
  assign x_start = (state == ST_ARM) & run & gate_rise & ~hold_off;
  assign x_done = (state == ST_END);
  assign x_len = count;
  assign busy = (state != ST_IDLE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cur <= '0;
      count <= '0;
      x_ts <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (run) begin
            cur <= first_idx;
            state <= ST_ARM;
          end
        end
        ST_ARM: begin
          if (!run) begin
            state <= ST_IDLE;
          end else if (x_start) begin
            count <= LEN_W'(want & s_ready);
            x_ts <= ts;
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (end_now) begin
            state <= ST_END;
          end else if (want && s_ready) begin
            count <= count + 1'b1;
            if (count == '0) begin
              x_ts <= ts;
            end
          end
        end
        ST_END: begin
          if (stop_tab[cur] || !run) begin
            state <= ST_IDLE;
          end else begin
            cur <= next_tab[cur];
            state <= ST_ARM;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule : adad_chan

// File: adad_engine.sv
// Four-channel acquisition engine with two bank writers and DMA readers.
// Assumes an external memory controller with single-word write and
// read ports per bank, and a host-facing word stream with ready.
//
// Function
// - Four independent acquisition channels, each feeding a DMA path.
// - Each channel selects a converter, the test ramp or playback loopback.
// - Each bank region works as a circular FIFO or a one-shot capture.
// - Each bank has a DMA reader moving committed words to the host.
// - Transfers follow a chain of descriptors, one transfer each.
// - Gate-driven descriptors last while the gate is high, up to 65535 samples.
// - With metadata on, a header holds channel, first-sample time, length.
// - Two banks hold the outgoing packets as FIFO storage.
module adad_engine (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [adad_pkg::N_CHAN-1:0][adad_pkg::SAMPLE_W-1:0] adc_data,
  input wire logic [adad_pkg::N_CHAN-1:0] adc_valid,
  input wire logic [adad_pkg::N_CHAN-1:0][adad_pkg::SAMPLE_W-1:0] pb_data,
  input wire logic [adad_pkg::N_CHAN-1:0] pb_valid,
  input wire logic [adad_pkg::N_CHAN-1:0] gate_pin,
  input wire logic [adad_pkg::N_CHAN-1:0] run,
  input wire logic [adad_pkg::N_CHAN-1:0][adad_pkg::SRC_W-1:0] src_sel,
  input wire logic [adad_pkg::N_CHAN-1:0] mem_transient,
  input wire logic [adad_pkg::N_CHAN-1:0] meta_en,
  input wire logic [adad_pkg::N_CHAN-1:0][adad_pkg::DESC_IW-1:0] first_idx,
  input wire logic desc_wr,
  input wire logic [adad_pkg::CHAN_IW-1:0] desc_chan,
  input wire logic [adad_pkg::DESC_IW-1:0] desc_idx,
  input wire logic [adad_pkg::LEN_W-1:0] desc_len,
  input wire logic desc_gated,
  input wire logic [adad_pkg::DESC_IW-1:0] desc_next,
  input wire logic desc_stop,
  output logic [adad_pkg::N_BANK-1:0] bank_wr_valid,
  output logic [adad_pkg::N_BANK-1:0][adad_pkg::BANK_AW-1:0] bank_wr_addr,
  output logic [adad_pkg::N_BANK-1:0][adad_pkg::WORD_W-1:0] bank_wr_data,
  output logic [adad_pkg::N_BANK-1:0] bank_rd_valid,
  output logic [adad_pkg::N_BANK-1:0][adad_pkg::BANK_AW-1:0] bank_rd_addr,
  input wire logic [adad_pkg::N_BANK-1:0] bank_rd_data_valid,
  input wire logic [adad_pkg::N_BANK-1:0][adad_pkg::WORD_W-1:0] bank_rd_data,
  output logic [adad_pkg::N_BANK-1:0] tx_valid,
  output logic [adad_pkg::N_BANK-1:0][adad_pkg::WORD_W-1:0] tx_data,
  output logic [adad_pkg::N_BANK-1:0][adad_pkg::CHAN_IW-1:0] tx_chan,
  input wire logic [adad_pkg::N_BANK-1:0] tx_ready,
  output logic [adad_pkg::N_CHAN-1:0] busy,
  output logic [adad_pkg::N_CHAN-1:0] overrun
);
  import adad_pkg::*;

  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_SEND} adad_rd_t;

  // Free words left in a channel region
  function automatic logic [REGION_AW:0] room_f(
    input logic [REGION_AW:0] w,
    input logic [REGION_AW:0] r,
    input logic trans
  );
    room_f = trans ? (REGION_DEPTH - w) : (REGION_DEPTH - (w - r));
  endfunction : room_f

  logic [N_CHAN-1:0] s_valid, s_ready, x_start, x_done, ch_busy, dropped;
  logic [N_CHAN-1:0] hold_off, drain, hdr_wr, rd_adv, start;
  logic [N_CHAN-1:0][SAMPLE_W-1:0] s_data;
  logic [N_CHAN-1:0][LEN_W-1:0] x_len;
  logic [N_CHAN-1:0][TS_W-1:0] x_ts;
  logic [TS_W-1:0] ts;
  logic [N_CHAN-1:0][REGION_AW:0] wptr, rptr, cptr, hbase, room;
  logic [N_CHAN-1:0] hold_full, meta_on, commit_pend, run_q, trans_on;
  logic [N_CHAN-1:0][SAMPLE_W-1:0] hold;
  logic [N_CHAN-1:0][1:0] hdr_cnt;
  logic [N_CHAN-1:0][LEN_W-1:0] hdr_len;
  logic [N_CHAN-1:0][TS_W-1:0] hdr_ts;
  logic [N_BANK-1:0] wr_go, wr_hdr, wr_sel, wr_rr;
  adad_rd_t rd_state [N_BANK];
  logic [N_BANK-1:0] rd_sel, rd_rr;

  // ---------------------------------------------------------------
  // Channels and sample clock time stamp
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ts <= '0;
    end else begin
      ts <= ts + 1'b1;
    end
  end

  for (genvar c = 0; c < N_CHAN; c++) begin : g_chan
    assign room[c] = room_f(wptr[c], rptr[c], trans_on[c]);
    assign hold_off[c] = commit_pend[c] | hold_full[c]
                       | (room[c] < META_WORDS + 1'b1);
    assign s_ready[c] = (~hold_full[c] | drain[c])
                      & (room[c] > {{REGION_AW{1'b0}}, hold_full[c]});
    assign start[c] = run[c] & ~run_q[c] & ~ch_busy[c] & ~commit_pend[c]
                    & ~hold_full[c] & (cptr[c] == rptr[c]);
    adad_chan #(.CHAN_ID(c)) u_chan (
      .clk(clk),
      .reset_n(reset_n),
      .gate_pin(gate_pin[c]),
      .src_sel(src_sel[c]),
      .adc_data(adc_data),
      .adc_valid(adc_valid),
      .pb_data(pb_data),
      .pb_valid(pb_valid),
      .run(run[c]),
      .hold_off(hold_off[c]),
      .desc_wr(desc_wr && (desc_chan == CHAN_IW'(c))),
      .desc_idx(desc_idx),
      .desc_len(desc_len),
      .desc_gated(desc_gated),
      .desc_next(desc_next),
      .desc_stop(desc_stop),
      .first_idx(first_idx[c]),
      .ts(ts),
      .s_ready(s_ready[c]),
      .s_valid(s_valid[c]),
      .s_data(s_data[c]),
      .x_start(x_start[c]),
      .x_done(x_done[c]),
      .x_len(x_len[c]),
      .x_ts(x_ts[c]),
      .busy(ch_busy[c]),
      .dropped(dropped[c])
    );
  end

  // ---------------------------------------------------------------
  // Bank write arbitration: headers first, then round-robin samples
  // ---------------------------------------------------------------
  always_comb begin
    drain = '0;
    hdr_wr = '0;
    for (int b = 0; b < N_BANK; b++) begin
      wr_go[b] = 1'b1;
      wr_hdr[b] = 1'b1;
      wr_sel[b] = 1'b0;
      if (hdr_cnt[2*b] != 2'h0) begin
        wr_sel[b] = 1'b0;
      end else if (hdr_cnt[2*b+1] != 2'h0) begin
        wr_sel[b] = 1'b1;
      end else if (hold_full[2*b] && (!hold_full[2*b+1] || !wr_rr[b])) begin
        wr_hdr[b] = 1'b0;
      end else if (hold_full[2*b+1]) begin
        wr_hdr[b] = 1'b0;
        wr_sel[b] = 1'b1;
      end else begin
        wr_go[b] = 1'b0;
        wr_hdr[b] = 1'b0;
      end
      drain[2*b+wr_sel[b]] = wr_go[b] & ~wr_hdr[b];
      hdr_wr[2*b+wr_sel[b]] = wr_go[b] & wr_hdr[b];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_wr_valid <= '0;
      bank_wr_addr <= '0;
      bank_wr_data <= '0;
      wr_rr <= '0;
    end else begin
      for (int b = 0; b < N_BANK; b++) begin
        bank_wr_valid[b] <= wr_go[b];
        if (wr_go[b] && wr_hdr[b]) begin
          bank_wr_addr[b] <= {wr_sel[b], hbase[2*b+wr_sel[b]][REGION_AW-1:0]
            + ((hdr_cnt[2*b+wr_sel[b]] == HDR_WORDS) ? 10'h000 : 10'h001)};
          bank_wr_data[b] <= (hdr_cnt[2*b+wr_sel[b]] == HDR_WORDS)
            ? {CHAN_IW'(2*b) | CHAN_IW'(wr_sel[b]), 6'h00, HDR_PAD,
               hdr_len[2*b+wr_sel[b]]}
            : hdr_ts[2*b+wr_sel[b]];
        end else if (wr_go[b]) begin
          bank_wr_addr[b] <= {wr_sel[b], wptr[2*b+wr_sel[b]][REGION_AW-1:0]};
          bank_wr_data[b] <= {16'h0000, hold[2*b+wr_sel[b]]};
          wr_rr[b] <= ~wr_sel[b];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Per-channel region pointers, hold slot and packet commit
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wptr <= '0;
      rptr <= '0;
      cptr <= '0;
      hbase <= '0;
      hold <= '0;
      hold_full <= '0;
      meta_on <= '0;
      trans_on <= '0;
      commit_pend <= '0;
      run_q <= '0;
      hdr_cnt <= '0;
      hdr_len <= '0;
      hdr_ts <= '0;
    end else begin
      run_q <= run;
      for (int c = 0; c < N_CHAN; c++) begin
        if (start[c]) begin
          wptr[c] <= '0;
          rptr[c] <= '0;
          cptr[c] <= '0;
          trans_on[c] <= mem_transient[c];
        end else begin
          if (x_start[c]) begin
            hbase[c] <= wptr[c];
            meta_on[c] <= meta_en[c];
            wptr[c] <= wptr[c] + (meta_en[c] ? META_WORDS : '0);
          end else if (drain[c]) begin
            wptr[c] <= wptr[c] + 1'b1;
          end
          if (rd_adv[c]) begin
            rptr[c] <= rptr[c] + 1'b1;
          end
          if (commit_pend[c] && hdr_cnt[c] == 2'h0 && !hold_full[c]) begin
            cptr[c] <= wptr[c];
          end
        end
        if (s_valid[c] && s_ready[c]) begin
          hold[c] <= s_data[c];
          hold_full[c] <= 1'b1;
        end else if (drain[c]) begin
          hold_full[c] <= 1'b0;
        end
        if (x_done[c]) begin
          commit_pend[c] <= 1'b1;
          hdr_len[c] <= x_len[c];
          hdr_ts[c] <= x_ts[c];
          hdr_cnt[c] <= meta_on[c] ? HDR_WORDS : 2'h0;
        end else begin
          if (hdr_wr[c]) begin
            hdr_cnt[c] <= hdr_cnt[c] - 1'b1;
          end
          if (commit_pend[c] && hdr_cnt[c] == 2'h0 && !hold_full[c]) begin
            commit_pend[c] <= 1'b0;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // DMA readers: one word in flight per bank
  // ---------------------------------------------------------------
  always_comb begin
    rd_adv = '0;
    for (int b = 0; b < N_BANK; b++) begin
      rd_adv[2*b+rd_sel[b]] = (rd_state[b] == RD_SEND) & tx_ready[b];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int b = 0; b < N_BANK; b++) begin
        rd_state[b] <= RD_IDLE;
      end
      rd_sel <= '0;
      rd_rr <= '0;
      bank_rd_valid <= '0;
      bank_rd_addr <= '0;
      tx_valid <= '0;
      tx_data <= '0;
      tx_chan <= '0;
    end else begin
      for (int b = 0; b < N_BANK; b++) begin
        bank_rd_valid[b] <= 1'b0;
        case (rd_state[b])
          RD_IDLE: begin
            if (cptr[2*b] != rptr[2*b]
                && (cptr[2*b+1] == rptr[2*b+1] || !rd_rr[b])) begin
              rd_sel[b] <= 1'b0;
              bank_rd_valid[b] <= 1'b1;
              bank_rd_addr[b] <= {1'b0, rptr[2*b][REGION_AW-1:0]};
              rd_rr[b] <= 1'b1;
              rd_state[b] <= RD_WAIT;
            end else if (cptr[2*b+1] != rptr[2*b+1]) begin
              rd_sel[b] <= 1'b1;
              bank_rd_valid[b] <= 1'b1;
              bank_rd_addr[b] <= {1'b1, rptr[2*b+1][REGION_AW-1:0]};
              rd_rr[b] <= 1'b0;
              rd_state[b] <= RD_WAIT;
            end
          end
          RD_WAIT: begin
            if (bank_rd_data_valid[b]) begin
              tx_valid[b] <= 1'b1;
              tx_data[b] <= bank_rd_data[b];
              tx_chan[b] <= CHAN_IW'(2*b) | CHAN_IW'(rd_sel[b]);
              rd_state[b] <= RD_SEND;
            end
          end
          RD_SEND: begin
            if (tx_ready[b]) begin
              tx_valid[b] <= 1'b0;
              rd_state[b] <= RD_IDLE;
            end
          end
          default: rd_state[b] <= RD_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= '0;
      overrun <= '0;
    end else begin
      busy <= ch_busy;
      overrun <= dropped;
    end
  end
endmodule : adad_engine

// File: adad_engine_checker.sv
// Port-level assertions for the acquisition engine.
// Assumes one clock domain; bound to the engine below.
module adad_engine_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [adad_pkg::N_CHAN-1:0] run,
  input wire logic [adad_pkg::N_BANK-1:0] bank_rd_valid,
  input wire logic [adad_pkg::N_BANK-1:0] bank_rd_data_valid,
  input wire logic [adad_pkg::N_BANK-1:0][adad_pkg::WORD_W-1:0] bank_rd_data,
  input wire logic [adad_pkg::N_BANK-1:0] tx_valid,
  input wire logic [adad_pkg::N_BANK-1:0][adad_pkg::WORD_W-1:0] tx_data,
  input wire logic [adad_pkg::N_BANK-1:0][adad_pkg::CHAN_IW-1:0] tx_chan,
  input wire logic [adad_pkg::N_BANK-1:0] tx_ready,
  input wire logic [adad_pkg::N_CHAN-1:0] busy
);
  import adad_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence gap0_s;
    !bank_rd_valid[0] [*4];
  endsequence
  sequence stall1_s;
    tx_valid[1] && !tx_ready[1];
  endsequence

  wake_quiet_a: assert property (
    $rose(reset_n) |-> tx_valid == '0 && busy == '0)
    else $error("outputs active at reset release");
  rd_single_a: assert property (bank_rd_valid[0] |=> gap0_s)
    else $error("second bank read too soon");
  rd_return0_a: assert property (
    bank_rd_data_valid[0] |=>
      tx_valid[0] && tx_data[0] == $past(bank_rd_data[0]))
    else $error("bank 0 word not forwarded");
  rd_return1_a: assert property (
    bank_rd_data_valid[1] |=>
      tx_valid[1] && tx_data[1] == $past(bank_rd_data[1]))
    else $error("bank 1 word not forwarded");
  tx_drop_a: assert property (
    tx_valid[0] && tx_ready[0] |=> !tx_valid[0])
    else $error("bank 0 word held after accept");
  tx_hold_a: assert property (
    stall1_s |=> tx_valid[1] && $stable(tx_data[1]))
    else $error("bank 1 word changed while stalled");
  tx_cause_a: assert property (
    $rose(tx_valid[1]) |-> $past(bank_rd_data_valid[1]))
    else $error("bank 1 word without read return");
  chan_bank0_a: assert property (tx_valid[0] |-> !tx_chan[0][1])
    else $error("wrong channel in bank 0");
  chan_bank1_a: assert property (tx_valid[1] |-> tx_chan[1][1])
    else $error("wrong channel in bank 1");
  busy_run_a: assert property ($rose(busy[2]) |-> $past(run[2]))
    else $error("channel left idle without run");
endmodule : adad_engine_checker

bind adad_engine adad_engine_checker i_chk (
  .clk(clk), .reset_n(reset_n), .run(run),
  .bank_rd_valid(bank_rd_valid), .bank_rd_data_valid(bank_rd_data_valid),
  .bank_rd_data(bank_rd_data), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_chan(tx_chan), .tx_ready(tx_ready), .busy(busy)
);

// File: adad_engine_tb.sv
// Self-checking bench for the four-channel acquisition engine.
// Assumes adad_mem_model as memory and host; streams count per cycle.
module adad_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adad_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic slow = 1'b0;
  logic [N_CHAN-1:0][SAMPLE_W-1:0] adc_data = '0, pb_data = '0;
  logic [N_CHAN-1:0] adc_valid = '1, pb_valid = '1, gate_pin = '0, run = '0;
  logic [N_CHAN-1:0] mem_transient = '0, meta_en = '0;
  logic [N_CHAN-1:0][SRC_W-1:0] src_sel = '0;
  logic [N_CHAN-1:0][DESC_IW-1:0] first_idx = '0;
  logic desc_wr = 1'b0, desc_gated = 1'b0, desc_stop = 1'b0;
  logic [CHAN_IW-1:0] desc_chan = '0;
  logic [DESC_IW-1:0] desc_idx = '0, desc_next = '0;
  logic [LEN_W-1:0] desc_len = '0;
  logic [N_BANK-1:0] bank_wr_valid, bank_rd_valid, bank_rd_data_valid;
  logic [N_BANK-1:0][BANK_AW-1:0] bank_wr_addr, bank_rd_addr;
  logic [N_BANK-1:0][WORD_W-1:0] bank_wr_data, bank_rd_data, tx_data;
  logic [N_BANK-1:0] tx_valid, tx_ready;
  logic [N_BANK-1:0][CHAN_IW-1:0] tx_chan;
  logic [N_CHAN-1:0] busy, overrun;
  logic [11:0] cnt = '0;
  logic [31:0] q0[$], q1[$];
  int n_mismatch = 0, compares = 0, cyc = 0;

  adad_engine i_dut (.clk, .reset_n, .adc_data, .adc_valid, .pb_data,
    .pb_valid, .gate_pin, .run, .src_sel, .mem_transient, .meta_en,
    .first_idx, .desc_wr, .desc_chan, .desc_idx, .desc_len, .desc_gated,
    .desc_next, .desc_stop, .bank_wr_valid, .bank_wr_addr, .bank_wr_data,
    .bank_rd_valid, .bank_rd_addr, .bank_rd_data_valid, .bank_rd_data,
    .tx_valid, .tx_data, .tx_chan, .tx_ready, .busy, .overrun);
  adad_mem_model i_mem (.clk, .reset_n, .slow, .bank_wr_valid,
    .bank_wr_addr, .bank_wr_data, .bank_rd_valid, .bank_rd_addr,
    .bank_rd_data_valid, .bank_rd_data, .tx_ready);

  initial forever #5 clk = ~clk;
  // Converters carry their index in the top nibble, playback sources their index plus 8
  always @(posedge clk) begin
    cnt <= cnt + 12'h1;
    for (int k = 0; k < N_CHAN; k++) begin
      adc_data[k] <= {4'(k), cnt};
      pb_data[k] <= {4'(k + 8), cnt};
    end
    if (tx_valid[0] && tx_ready[0]) q0.push_back(tx_data[0]);
    if (tx_valid[1] && tx_ready[1]) q1.push_back(tx_data[1]);
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic take(input int b, output logic [31:0] w);
    int t;
    t = 0;
    while ((b == 0 ? q0.size() : q1.size()) == 0 && t < 2000) begin
      @(posedge clk);
      t++;
    end
    w = 32'hx;
    if (b == 0 && q0.size() > 0) w = q0.pop_front();
    if (b == 1 && q1.size() > 0) w = q1.pop_front();
  endtask : take

  task automatic samples(input int b, input int n, input logic [3:0] src,
      input string what);
    logic [31:0] w, p;
    take(b, p);
    cmp(what, {16'h0, src, p[11:0]}, p);
    for (int i = 1; i < n; i++) begin
      take(b, w);
      cmp(what, {16'h0, src, p[11:0] + 12'h1}, w);
      p = w;
    end
  endtask : samples

  // Leaves desc_wr high so back-to-back writes need no gap
  task automatic put_desc(input logic [1:0] ch, input logic [2:0] idx,
      input logic [15:0] len, input logic gated, input logic [2:0] nxt,
      input logic stop);
    desc_wr <= 1'b1;
    desc_chan <= ch;
    desc_idx <= idx;
    desc_len <= len;
    desc_gated <= gated;
    desc_next <= nxt;
    desc_stop <= stop;
    @(posedge clk);
  endtask : put_desc

  task automatic pulse(input int ch, input int n);
    gate_pin[ch] <= 1'b1;
    repeat (n) @(posedge clk);
    gate_pin[ch] <= 1'b0;
  endtask : pulse

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_length;
    logic [31:0] w;
    put_desc(2'h0, 3'h0, 16'h4, 1'b0, 3'h0, 1'b1);
    desc_wr <= 1'b0;
    src_sel[0] <= 3'h3;
    meta_en[0] <= 1'b1;
    run[0] <= 1'b1;
    repeat (4) @(posedge clk);
    pulse(0, 6);
    take(0, w);
    cmp("length header", {2'h0, 14'h0, 16'h4}, w);
    take(0, w);
    samples(0, 4, 4'h3, "length sample");
    run[0] <= 1'b0;
    repeat (30) @(posedge clk);
    cmp("length extra", 32'h0, 32'(q0.size()));
    cmp("length busy", 32'h0, 32'(busy[0]));
    $display("test length done");
  endtask : t_length

  task automatic t_gated;
    logic [31:0] w;
    put_desc(2'h2, 3'h0, 16'h0, 1'b1, 3'h1, 1'b0);
    put_desc(2'h2, 3'h1, 16'h3, 1'b0, 3'h0, 1'b1);
    desc_wr <= 1'b0;
    src_sel[2] <= SRC_LOOP;
    meta_en[2] <= 1'b1;
    slow <= 1'b1;
    run[2] <= 1'b1;
    repeat (4) @(posedge clk);
    pulse(2, 10);
    repeat (40) @(posedge clk);
    pulse(2, 8);
    take(1, w);
    cmp("gated header", {2'h2, 14'h0, 16'ha}, w);
    take(1, w);
    samples(1, 10, 4'ha, "gated sample");
    take(1, w);
    cmp("chained header", {2'h2, 14'h0, 16'h3}, w);
    take(1, w);
    samples(1, 3, 4'ha, "chained sample");
    slow <= 1'b0;
    run[2] <= 1'b0;
    $display("test gated done");
  endtask : t_gated

  task automatic t_oneshot;
    logic [31:0] w;
    put_desc(2'h1, 3'h0, 16'h2, 1'b0, 3'h0, 1'b1);
    desc_wr <= 1'b0;
    src_sel[1] <= SRC_TEST;
    mem_transient[1] <= 1'b1;
    run[1] <= 1'b1;
    repeat (4) @(posedge clk);
    pulse(1, 5);
    for (int i = 0; i < 2; i++) begin
      take(0, w);
      cmp("ramp upper", 32'h0, {16'h0, w[31:16]});
    end
    repeat (30) @(posedge clk);
    cmp("no header", 32'h0, 32'(q0.size()));
    $display("test oneshot done");
  endtask : t_oneshot

  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    cmp("reset outputs", 32'h0, 32'({busy, overrun, tx_valid,
      bank_wr_valid, bank_rd_valid}));
    $display("test reset done");
    @(posedge clk);
    t_length();
    t_gated();
    t_oneshot();
    conclude();
  end
endmodule : adad_engine_tb

// File: adad_mem_model.sv
// Behavioural bank memories and host sink facing the engine.
// Assumes single-word bank ports; slow adds read latency and tx stalls.
module adad_mem_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic [adad_pkg::N_BANK-1:0] bank_wr_valid,
  input wire logic [adad_pkg::N_BANK-1:0][adad_pkg::BANK_AW-1:0] bank_wr_addr,
  input wire logic [adad_pkg::N_BANK-1:0][adad_pkg::WORD_W-1:0] bank_wr_data,
  input wire logic [adad_pkg::N_BANK-1:0] bank_rd_valid,
  input wire logic [adad_pkg::N_BANK-1:0][adad_pkg::BANK_AW-1:0] bank_rd_addr,
  output logic [adad_pkg::N_BANK-1:0] bank_rd_data_valid,
  output logic [adad_pkg::N_BANK-1:0][adad_pkg::WORD_W-1:0] bank_rd_data,
  output logic [adad_pkg::N_BANK-1:0] tx_ready
);
  import adad_pkg::*;
  logic [WORD_W-1:0] mem [N_BANK][2**BANK_AW];
  logic [1:0] dly [N_BANK];
  logic [BANK_AW-1:0] addr [N_BANK];
  logic [N_BANK-1:0] pend;
  logic [1:0] tick;

  always_ff @(posedge clk) begin
    for (int b = 0; b < N_BANK; b++)
      if (bank_wr_valid[b]) mem[b][bank_wr_addr[b]] <= bank_wr_data[b];
  end

  // Idle read data toggles so stale words never look valid
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend <= '0;
      bank_rd_data_valid <= '0;
      bank_rd_data <= '0;
      for (int b = 0; b < N_BANK; b++) begin
        dly[b] <= 2'h0;
        addr[b] <= '0;
      end
    end else begin
      for (int b = 0; b < N_BANK; b++) begin
        bank_rd_data_valid[b] <= 1'b0;
        bank_rd_data[b] <= ~bank_rd_data[b];
        if (bank_rd_valid[b]) begin
          pend[b] <= 1'b1;
          addr[b] <= bank_rd_addr[b];
          dly[b] <= slow ? 2'h3 : 2'h0;
        end else if (pend[b] && dly[b] != 2'h0) begin
          dly[b] <= dly[b] - 2'h1;
        end else if (pend[b]) begin
          pend[b] <= 1'b0;
          bank_rd_data_valid[b] <= 1'b1;
          bank_rd_data[b] <= mem[b][addr[b]];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tick <= 2'h0;
    else tick <= tick + 2'h1;
  end
  assign tx_ready = (!slow || tick == 2'h3) ? '1 : '0;
endmodule : adad_mem_model
